// [logic/frg_defines.vh]
// constants for the flash reset and write guard block
// assumes a 100 MHz core clock; all times are rounded to whole core cycles
`ifndef FRG_DEFINES_VH
`define FRG_DEFINES_VH

// instruction codes
`define FRG_CMD_WREN     8'h06
`define FRG_CMD_WRDI     8'h04
`define FRG_CMD_RDSR1    8'h05
`define FRG_CMD_RDSR2    8'h35
`define FRG_CMD_WRSR1    8'h01
`define FRG_CMD_WRSR2    8'h31
`define FRG_CMD_PP       8'h02
`define FRG_CMD_QPP      8'h32
`define FRG_CMD_SE       8'h20
`define FRG_CMD_BE       8'hD8
`define FRG_CMD_CE1      8'hC7
`define FRG_CMD_CE2      8'h60
`define FRG_CMD_SUSP     8'h75
`define FRG_CMD_PD       8'hB9
`define FRG_CMD_RPD      8'hAB
`define FRG_CMD_RSTEN    8'h66
`define FRG_CMD_RST      8'h99

// status_one bit positions
`define FRG_S1_BUSY      0
`define FRG_S1_LATCH     1
`define FRG_S1_BG_LO     2
`define FRG_S1_BG_HI     4
`define FRG_S1_TB        5
`define FRG_S1_SEC       6
`define FRG_S1_LOCK_LO   7
// status_two bit positions (S8 is bit 0)
`define FRG_S2_LOCK_HI   0
`define FRG_S2_QE        1
`define FRG_S2_CMP       6

// reset values of the configuration bits
`define FRG_BG_RST       3'h0
`define FRG_BIT_RST      1'b0

// timing: figures in ns, counts derived from the core period
`define FRG_CLK_NS       10
`define FRG_SWR_NS       28000
`define FRG_SWR_CYC      ((`FRG_SWR_NS + `FRG_CLK_NS - 1) / `FRG_CLK_NS)
`define FRG_HWP_NS       1000
`define FRG_HWP_CYC      ((`FRG_HWP_NS + `FRG_CLK_NS - 1) / `FRG_CLK_NS)

// synchroniser idle levels {sclk, csN, mosi, wpN, sharedN}
`define FRG_PIN_IDLE     5'h0B

`endif

// [logic/frg_guard.v]
// reset and write-protection control of a serial flash, seen from the serial pins
// assumes a standard spi host on the pins; sys_rst stands for a power cycle
`timescale 1ns/10ps
`include "frg_defines.vh"
module frg_guard #(
    parameter [19:0] PU_CYCLES     = 20'd100000,
    parameter [19:0] PROG_CYCLES   = 20'd500,
    parameter [19:0] ERASE_CYCLES  = 20'd2000,
    parameter [19:0] STATUS_CYCLES = 20'd300
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       sys_rst,
    // serial pins
    input  wire       spiClk,
    input  wire       spiCsN,
    input  wire       spiDataIn,
    output wire       spiDataOut,
    output wire       spiDataOutEn,
    // protect pin and shared pause / reset pin
    input  wire       protectN,
    input  wire       sharedPinN,
    input  wire       resetPinSel,
    // status and configuration
    output wire [7:0] statusOne,
    output wire [7:0] statusTwo,
    output wire       busy,
    output wire       writeLatch,
    output wire       quadIoEnable,
    output wire [2:0] blockGuardBits,
    output wire       guardFromBottom,
    output wire       guardGranuleSmall,
    output wire       guardInvert,
    // reset and pause state
    output wire       resetBusy,
    output wire       hwResetLow,
    output reg        pauseActive,
    output reg        opAbort
);
    localparam integer SWR_CYC = `FRG_SWR_CYC;
    localparam integer HWP_CYC = `FRG_HWP_CYC;
    // operation kinds, one-hot
    localparam [2:0] OP_PROG  = 3'h1;
    localparam [2:0] OP_ERASE = 3'h2;
    localparam [2:0] OP_STAT  = 3'h4;

    wire [4:0] pinSync;
    wire       sclkS;
    wire       csS;
    wire       mosiS;
    wire       protS;
    wire       sharedS;
    reg        sclkPrev;
    reg        csPrev;

    // configuration and volatile state
    reg        latchBit;
    reg  [2:0] guardBits;
    reg        fromBottom;
    reg        granuleSmall;
    reg        invertBit;
    reg        lockLo;
    reg        lockHi;
    reg        quadEn;
    reg        resetPending;
    reg        powerDown;
    reg        puStarted;

    // frame state
    reg        frameOk;
    reg  [2:0] bitCnt;
    reg  [1:0] byteCnt;
    reg  [7:0] shiftIn;
    reg  [7:0] cmdReg;
    reg  [7:0] dataOne;
    reg  [7:0] dataTwo;
    reg  [7:0] shiftOut;
    reg        readArmed;
    reg        reading;
    reg  [7:0] hwCnt;

    wire        opActive;
    wire        opDone;
    wire        swrActive;
    wire        puActive;
    reg         opLoad;
    reg  [19:0] opVal;
    reg         swrLoad;

    frg_sync #(
        .W    (5),
        .INIT (`FRG_PIN_IDLE)
    ) pinSyncInst (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pinIn    ({spiClk, spiCsN, spiDataIn, protectN, sharedPinN}),
        .pinSync  (pinSync)
    );

    assign sclkS   = pinSync[4];
    assign csS     = pinSync[3];
    assign mosiS   = pinSync[2];
    assign protS   = pinSync[1];
    assign sharedS = pinSync[0];

    // pin role: quad enable takes the pin away from both functions
    wire pinIsReset = resetPinSel & ~quadEn;
    wire pinIsPause = ~resetPinSel & ~quadEn;
    wire hwLow      = pinIsReset & ~sharedS;
    wire hwHit      = hwLow && (hwCnt == HWP_CYC[7:0] - 8'h01);
    wire hwQual     = hwLow && (hwCnt == HWP_CYC[7:0]);

    wire sclkRise = sclkS & ~sclkPrev;
    wire sclkFall = ~sclkS & sclkPrev;
    wire csStart  = ~csS & csPrev;
    wire csEnd    = csS & ~csPrev;

    // the serial side is deaf during any reset interval
    wire ignoreIo = hwLow | swrActive;
    wire shiftEn  = sclkRise & ~csS & ~pauseActive & frameOk;
    wire byteDone = shiftEn && (bitCnt == 3'h7);
    wire [7:0] byteIn = {shiftIn[6:0], mosiS};

    // a clean frame ends on a byte boundary with at least the command
    wire frameEnd = csEnd & frameOk & (bitCnt == 3'h0) & (byteCnt != 2'h0);

    // instruction classes
    wire isWrsr  = (cmdReg == `FRG_CMD_WRSR1) | (cmdReg == `FRG_CMD_WRSR2);
    wire isProg  = (cmdReg == `FRG_CMD_PP) | (cmdReg == `FRG_CMD_QPP);
    wire isErase = (cmdReg == `FRG_CMD_SE) | (cmdReg == `FRG_CMD_BE)
                 | (cmdReg == `FRG_CMD_CE1) | (cmdReg == `FRG_CMD_CE2);
    wire isWrite = isWrsr | isProg | isErase | (cmdReg == `FRG_CMD_WREN);
    wire isBusyOk = (cmdReg == `FRG_CMD_RDSR1) | (cmdReg == `FRG_CMD_RDSR2)
                  | (cmdReg == `FRG_CMD_SUSP);
    wire puBlock = ~puStarted | puActive;

    // gate of acceptance, strongest refusal first
    wire accepted = frameEnd
                  & (~powerDown | (cmdReg == `FRG_CMD_RPD))
                  & (~opActive | isBusyOk)
                  & ~(puBlock & isWrite);

    // status lock: protect pin only counts while it is not a data line
    wire protLow  = ~quadEn & ~protS;
    wire lockOpen = ~lockHi & (~lockLo | ~protLow);
    wire wrsrLen  = (byteCnt >= 2'h2);
    wire doWrsr   = accepted & isWrsr & latchBit & lockOpen & wrsrLen;
    wire doProg   = accepted & isProg & latchBit;
    wire doErase  = accepted & isErase & latchBit;
    wire swrStart = accepted & (cmdReg == `FRG_CMD_RST) & resetPending;
    wire volClear = swrStart | hwHit;

    // timer loads for operations and the software reset interval
    always @* begin
        opLoad  = doWrsr | doProg | doErase;
        swrLoad = swrStart;
        if (doProg) begin
            opVal = PROG_CYCLES;
        end else if (doErase) begin
            opVal = ERASE_CYCLES;
        end else begin
            opVal = STATUS_CYCLES;
        end
    end

    frg_timer #(.CW (20)) opTimer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clear    (volClear),
        .load     (opLoad),
        .loadVal  (opVal),
        .active   (opActive),
        .done     (opDone)
    );

    frg_timer #(.CW (20)) swrTimer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clear    (1'b0),
        .load     (swrLoad),
        .loadVal  (SWR_CYC[19:0]),
        .active   (swrActive),
        .done     ()
    );

    frg_timer #(.CW (20)) puTimer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clear    (1'b0),
        .load     (~puStarted),
        .loadVal  (PU_CYCLES),
        .active   (puActive),
        .done     ()
    );

    // edge history and power-up delay start
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sclkPrev  <= 1'b0;
            csPrev    <= 1'b1;
            puStarted <= 1'b0;
        end else begin
            sclkPrev  <= sclkS;
            csPrev    <= csS;
            puStarted <= 1'b1;
        end
    end

    // reset pin filter: counts low time, saturates once qualified
    always @(posedge core_clk) begin
        if (sys_rst || !hwLow) begin
            hwCnt <= 8'h00;
        end else if (!hwQual) begin
            hwCnt <= hwCnt + 8'h01;
        end
    end

    // pause follows the pin only while the serial clock is low
    always @(posedge core_clk) begin
        if (sys_rst || !pinIsPause || csS || hwLow) begin
            pauseActive <= 1'b0;
        end else if (!sclkS) begin
            pauseActive <= ~sharedS;
        end
    end

    // abort pulse when a reset cuts an operation short
    always @(posedge core_clk) begin
        if (sys_rst) begin
            opAbort <= 1'b0;
        end else begin
            opAbort <= volClear & opActive;
        end
    end

    // frame capture; a frame touched by a reset interval is dropped whole
    always @(posedge core_clk) begin
        if (sys_rst || ignoreIo) begin
            frameOk <= 1'b0;
            bitCnt  <= 3'h0;
            byteCnt <= 2'h0;
            shiftIn <= 8'h00;
            cmdReg  <= 8'h00;
            dataOne <= 8'h00;
            dataTwo <= 8'h00;
        end else if (csStart) begin
            frameOk <= 1'b1;
            bitCnt  <= 3'h0;
            byteCnt <= 2'h0;
        end else if (csEnd) begin
            frameOk <= 1'b0;
        end else if (shiftEn) begin
            shiftIn <= byteIn;
            bitCnt  <= bitCnt + 3'h1;
            if (byteDone) begin
                if (byteCnt == 2'h0) begin
                    cmdReg <= byteIn;
                end else if (byteCnt == 2'h1) begin
                    dataOne <= byteIn;
                end else if (byteCnt == 2'h2) begin
                    dataTwo <= byteIn;
                end
                if (byteCnt != 2'h3) begin
                    byteCnt <= byteCnt + 2'h1;
                end
            end
        end
    end

    // status read: loaded at the command byte, shifted on falling edges
    always @(posedge core_clk) begin
        if (sys_rst || ignoreIo || csS) begin
            reading   <= 1'b0;
            readArmed <= 1'b0;
            shiftOut  <= 8'h00;
        end else if (byteDone && byteCnt == 2'h0 && !powerDown) begin
            reading   <= (byteIn == `FRG_CMD_RDSR1) | (byteIn == `FRG_CMD_RDSR2);
            readArmed <= 1'b0;
            shiftOut  <= (byteIn == `FRG_CMD_RDSR2) ? statusTwo : statusOne;
        end else if (reading && sclkFall && !pauseActive) begin
            // first fall keeps the msb that is already on the pin
            readArmed <= 1'b1;
            if (readArmed) begin
                shiftOut <= {shiftOut[6:0], shiftOut[7]};
            end
        end
    end

    // write latch and reset-enable bookkeeping
    always @(posedge core_clk) begin
        if (sys_rst || volClear) begin
            latchBit     <= 1'b0;
            resetPending <= 1'b0;
            powerDown    <= 1'b0;
        end else begin
            if (opDone) begin
                latchBit <= 1'b0;
            end else if (accepted && cmdReg == `FRG_CMD_WREN) begin
                latchBit <= 1'b1;
            end else if (accepted && cmdReg == `FRG_CMD_WRDI) begin
                latchBit <= 1'b0;
            end
            if (accepted) begin
                resetPending <= (cmdReg == `FRG_CMD_RSTEN);
            end
            if (accepted && cmdReg == `FRG_CMD_PD) begin
                powerDown <= 1'b1;
            end else if (accepted && cmdReg == `FRG_CMD_RPD) begin
                powerDown <= 1'b0;
            end
        end
    end

    // guard and lock bits survive software and pin resets, not a power cycle
    always @(posedge core_clk) begin
        if (sys_rst) begin
            guardBits    <= `FRG_BG_RST;
            fromBottom   <= `FRG_BIT_RST;
            granuleSmall <= `FRG_BIT_RST;
            invertBit    <= `FRG_BIT_RST;
            lockLo       <= `FRG_BIT_RST;
            lockHi       <= `FRG_BIT_RST;
            quadEn       <= `FRG_BIT_RST;
        end else if (doWrsr) begin
            if (cmdReg == `FRG_CMD_WRSR1) begin
                guardBits    <= dataOne[`FRG_S1_BG_HI:`FRG_S1_BG_LO];
                fromBottom   <= dataOne[`FRG_S1_TB];
                granuleSmall <= dataOne[`FRG_S1_SEC];
                lockLo       <= dataOne[`FRG_S1_LOCK_LO];
            end
            // second status byte: after 01h it is the third byte
            if (cmdReg == `FRG_CMD_WRSR2 || byteCnt == 2'h3) begin
                lockHi    <= (cmdReg == `FRG_CMD_WRSR2) ? dataOne[`FRG_S2_LOCK_HI]
                                                        : dataTwo[`FRG_S2_LOCK_HI];
                quadEn    <= (cmdReg == `FRG_CMD_WRSR2) ? dataOne[`FRG_S2_QE]
                                                        : dataTwo[`FRG_S2_QE];
                invertBit <= (cmdReg == `FRG_CMD_WRSR2) ? dataOne[`FRG_S2_CMP]
                                                        : dataTwo[`FRG_S2_CMP];
            end
        end
    end

    // status images; unlisted bits read as zero
    assign statusOne = {lockLo, granuleSmall, fromBottom, guardBits, latchBit,
                        opActive};
    assign statusTwo = {1'b0, invertBit, 4'h0, quadEn, lockHi};

    assign spiDataOut        = shiftOut[7];
    assign spiDataOutEn      = reading & ~csS & ~pauseActive & frameOk;
    assign busy              = opActive;
    assign writeLatch        = latchBit;
    assign quadIoEnable      = quadEn;
    assign blockGuardBits    = guardBits;
    assign guardFromBottom   = fromBottom;
    assign guardGranuleSmall = granuleSmall;
    assign guardInvert       = invertBit;
    assign resetBusy         = swrActive;
    assign hwResetLow        = hwLow;
endmodule

// [logic/frg_sync.v]
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to core_clk
`timescale 1ns/10ps
module frg_sync #(
    parameter W    = 5,
    parameter INIT = 5'h0B
) (
    // clock and reset
    input  wire         core_clk,
    input  wire         sys_rst,
    // pins in, synchronised levels out
    input  wire [W-1:0] pinIn,
    output reg  [W-1:0] pinSync
);
    reg [W-1:0] stageOne;

    // first stage feeds only the second stage
    always @(posedge core_clk) begin
        if (sys_rst) begin
            stageOne <= INIT;
            pinSync  <= INIT;
        end else begin
            stageOne <= pinIn;
            pinSync  <= stageOne;
        end
    end
endmodule

// [logic/frg_timer.v]
// down counter: load a count, busy while non-zero, done on the last cycle
// assumes load and clear come from logic on core_clk
`timescale 1ns/10ps
module frg_timer #(
    parameter CW = 20
) (
    // clock and reset
    input  wire          core_clk,
    input  wire          sys_rst,
    // control
    input  wire          clear,
    input  wire          load,
    input  wire [CW-1:0] loadVal,
    // state
    output wire          active,
    output wire          done
);
    reg [CW-1:0] count;

    // clear beats load so an abort always ends the interval
    always @(posedge core_clk) begin
        if (sys_rst || clear) begin
            count <= {CW{1'b0}};
        end else if (load) begin
            count <= loadVal;
        end else if (count != {CW{1'b0}}) begin
            count <= count - 1'b1;
        end
    end

    assign active = (count != {CW{1'b0}});
    assign done   = (count == {{(CW-1){1'b0}}, 1'b1});
endmodule

// [tb/frg_guard_props.sv]
// checker for the reset and write guard, bound to the guard top
// assumes sys_rst stands for a power cycle and core_clk runs throughout
`timescale 1ns/10ps
module frg_guard_props #(
    parameter [19:0] PU_CYCLES = 20'h186A0
) (
    // clock and reset
    input wire       core_clk,
    input wire       sys_rst,
    // serial pins
    input wire       spiClk,
    input wire       spiCsN,
    input wire       spiDataIn,
    input wire       spiDataOut,
    input wire       spiDataOutEn,
    // protect and shared pin
    input wire       protectN,
    input wire       sharedPinN,
    input wire       resetPinSel,
    // status and state
    input wire [7:0] statusOne,
    input wire [7:0] statusTwo,
    input wire       busy,
    input wire       writeLatch,
    input wire       quadIoEnable,
    input wire [2:0] blockGuardBits,
    input wire       guardFromBottom,
    input wire       guardGranuleSmall,
    input wire       guardInvert,
    input wire       resetBusy,
    input wire       hwResetLow,
    input wire       pauseActive,
    input wire       opAbort
);
    reg [19:0] upCnt;
    reg [11:0] rbCnt;
    reg [6:0]  lowCnt;

    // counts since power-up, of the reset interval and of reset pin low; first and last saturate
    always @(posedge core_clk) begin
        if (sys_rst) begin
            upCnt  <= 20'h00000;
            rbCnt  <= 12'h000;
            lowCnt <= 7'h00;
        end else begin
            upCnt  <= (upCnt == 20'hFFFFF) ? upCnt : upCnt + 20'h00001;
            rbCnt  <= resetBusy ? rbCnt + 12'h001 : 12'h000;
            lowCnt <= !hwResetLow ? 7'h00 : (lowCnt == 7'h7F) ? lowCnt : lowCnt + 7'h01;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_pu_lockout: assert property (upCnt < PU_CYCLES |-> !writeLatch)
        else $error("write latch set inside the power-up delay");
    a_done_clears: assert property ($fell(busy) |-> ##[0:1] !writeLatch)
        else $error("write latch kept after an operation ended");
    a_latch_gate: assert property ($rose(writeLatch) |-> !busy && !resetBusy && !hwResetLow)
        else $error("write enable taken while commands are refused");
    a_status_map: assert property (statusOne[6:0] == {guardGranuleSmall, guardFromBottom,
        blockGuardBits, writeLatch, busy} && statusTwo[6:1] == {guardInvert, 4'h0, quadIoEnable})
        else $error("status byte disagrees with the bit outputs");
    a_quad_no_pin: assert property (quadIoEnable |-> !hwResetLow && !pauseActive)
        else $error("shared pin function active in quad mode");
    a_pause_role: assert property ((!resetPinSel) [*3] |-> !hwResetLow)
        else $error("reset pin active while pin selected as pause");
    a_abort_cause: assert property (opAbort |-> lowCnt >= 7'h62)
        else $error("abort without a long enough reset pulse");
    a_abort_once: assert property (opAbort |=> !opAbort)
        else $error("abort pulse longer than one cycle");
    a_abort_clear: assert property (opAbort |-> ##[0:1] (!busy && !writeLatch))
        else $error("abort left busy or write latch set");
    a_swr_span: assert property ($fell(resetBusy) |-> rbCnt >= 12'hAEF && rbCnt <= 12'hAF1)
        else $error("software reset interval has the wrong length");

    c_abort: cover property (opAbort);
    c_swr: cover property ($fell(resetBusy));
    c_pause: cover property (pauseActive);
endmodule

bind frg_guard frg_guard_props #(.PU_CYCLES(PU_CYCLES)) u_props (
    .core_clk, .sys_rst, .spiClk, .spiCsN, .spiDataIn, .spiDataOut, .spiDataOutEn,
    .protectN, .sharedPinN, .resetPinSel, .statusOne, .statusTwo, .busy, .writeLatch,
    .quadIoEnable, .blockGuardBits, .guardFromBottom, .guardGranuleSmall, .guardInvert,
    .resetBusy, .hwResetLow, .pauseActive, .opAbort
);

// [tb/frg_host.sv]
// spi host model: one command frame per call, mode 0, msb first
// assumes core_clk only paces frame starts; serial clock stands low outside frames
`timescale 1ns/10ps
module frg_host (
    // pacing clock
    input  wire core_clk,
    // serial pins
    input  wire spiDataOut,
    output reg  spiClk,
    output reg  spiCsN,
    output reg  spiDataIn
);
    reg [23:0] shiftReg;
    integer    i;

    // idle bus: deselected, clock parked low
    initial begin
        spiClk    = 1'b0;
        spiCsN    = 1'b1;
        spiDataIn = 1'b0;
    end

    // command plus n whole bytes; the byte after the command is read back
    task xfer(input [7:0] c, input [15:0] d, input [1:0] n, output [7:0] r);
        begin
            shiftReg = {c, d};
            r = 8'h00;
            @(posedge core_clk);
            #3 spiCsN = 1'b0;
            for (i = 0; i < 8 * (n + 1); i = i + 1) begin
                spiDataIn = shiftReg[23 - i];
                #62.5 spiClk = 1'b1;
                if (i >= 8 && i < 16)
                    r = {r[6:0], spiDataOut};
                #62.5 spiClk = 1'b0;
            end
            #62.5 spiCsN = 1'b1;
            // released line must not keep a stale level
            spiDataIn = ~spiDataIn;
            #250;
            @(posedge core_clk);
        end
    endtask
endmodule

// [tb/tb_top.sv]
// bench for the reset and write guard, driven through its serial pins
// assumes frg_host as spi host and the checker bound from its own file
`timescale 1ns/10ps
`include "frg_defines.vh"
module tb_top;
    reg         core_clk    = 1'b0;
    reg         sys_rst     = 1'b1;
    reg         protectN    = 1'b1;
    reg         sharedPinN  = 1'b1;
    reg         resetPinSel = 1'b0;
    wire        spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOutEn;
    wire [7:0]  statusOne, statusTwo;
    wire [2:0]  blockGuardBits;
    wire        busy, writeLatch, quadIoEnable, guardFromBottom, guardGranuleSmall;
    wire        guardInvert, resetBusy, hwResetLow, pauseActive, opAbort;
    integer     err_total   = 0;
    integer     checked     = 0;
    integer     j, k;
    reg  [7:0]  rv;
    reg  [47:0] ops = {`FRG_CMD_PP, `FRG_CMD_QPP, `FRG_CMD_SE,
                       `FRG_CMD_BE, `FRG_CMD_CE1, `FRG_CMD_CE2};

    // shorter erase, status and power-up times keep the run small; delays derive from these values
    frg_guard #(.PU_CYCLES(20'h0012C), .PROG_CYCLES(20'h00258), .ERASE_CYCLES(20'h001F4),
                .STATUS_CYCLES(20'h00064)) dut (
        .core_clk, .sys_rst, .spiClk, .spiCsN, .spiDataIn, .spiDataOut, .spiDataOutEn,
        .protectN, .sharedPinN, .resetPinSel, .statusOne, .statusTwo, .busy, .writeLatch,
        .quadIoEnable, .blockGuardBits, .guardFromBottom, .guardGranuleSmall, .guardInvert,
        .resetBusy, .hwResetLow, .pauseActive, .opAbort
    );
    frg_host host (.core_clk, .spiDataOut, .spiClk, .spiCsN, .spiDataIn);

    always #5 core_clk = ~core_clk;

    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("wrong value %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task chb(input string nm, input e, input g);
        begin
            chk(nm, {7'h00, e}, {7'h00, g});
        end
    endtask
    task idle(input integer n);
        begin
            repeat (n) @(posedge core_clk);
        end
    endtask
    task cmd(input [7:0] c);
        begin
            host.xfer(c, 16'h0000, 2'd0, rv);
        end
    endtask
    task rd(input [7:0] c);
        begin
            host.xfer(c, 16'h0000, 2'd1, rv);
        end
    endtask
    // bounded wait so a stuck flag cannot hang the run
    task waitq;
        begin
            for (k = 0; k < 4000 && (busy !== 1'b0 || resetBusy !== 1'b0); k = k + 1)
                @(posedge core_clk);
        end
    endtask
    task wsr(input [7:0] a, input [7:0] b);
        begin
            cmd(`FRG_CMD_WREN);
            host.xfer(`FRG_CMD_WRSR1, {a, b}, 2'd2, rv);
            waitq;
        end
    endtask
    task rst_cycle;
        begin
            sys_rst <= 1'b1;
            idle(8);
            sys_rst <= 1'b0;
            idle(320);
        end
    endtask
    task complete_run;
        begin
            $display("checked %0d err_total %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    initial begin
        #1000000;
        err_total = err_total + 1;
        complete_run;
    end

    initial begin
        idle(8);
        sys_rst <= 1'b0;
        idle(3);
        cmd(`FRG_CMD_WREN);
        chb("latch in delay", 1'b0, writeLatch);
        rd(`FRG_CMD_RDSR1);
        chk("status_one", 8'h00, rv);
        rd(`FRG_CMD_RDSR2);
        chk("status_two", 8'h00, rv);
        idle(200);
        $display("test power-up done");
        cmd(`FRG_CMD_WREN);
        chb("latch set", 1'b1, writeLatch);
        cmd(`FRG_CMD_WRDI);
        chb("latch clear", 1'b0, writeLatch);
        cmd(`FRG_CMD_PP);
        chb("busy no latch", 1'b0, busy);
        cmd(`FRG_CMD_WREN);
        cmd(`FRG_CMD_PP);
        rd(`FRG_CMD_RDSR1);
        chk("status in op", 8'h03, rv);
        cmd(`FRG_CMD_WRDI);
        chb("latch in op", 1'b1, writeLatch);
        waitq;
        chk("op end", 8'h00, {6'h00, busy, writeLatch});
        for (j = 0; j < 6; j = j + 1) begin
            cmd(`FRG_CMD_WREN);
            cmd(ops[47 - 8 * j -: 8]);
            chb("op busy", 1'b1, busy);
            waitq;
            chb("op latch", 1'b0, writeLatch);
        end
        $display("test latch done");
        protectN <= 1'b0;
        wsr(8'h7C, 8'h42);
        chk("status_one wr", 8'h7C, statusOne);
        rd(`FRG_CMD_RDSR2);
        chk("status_two wr", 8'h42, rv);
        resetPinSel <= 1'b1;
        sharedPinN <= 1'b0;
        idle(150);
        chb("pin in quad", 1'b0, hwResetLow);
        sharedPinN <= 1'b1;
        wsr(8'h80, 8'h42);
        wsr(8'h84, 8'h42);
        chk("quad ignores wp", 8'h84, statusOne);
        wsr(8'h80, 8'h00);
        wsr(8'h88, 8'h00);
        // a refused status write leaves the write latch set
        chk("wp low", 8'h82, statusOne);
        protectN <= 1'b1;
        wsr(8'h00, 8'h01);
        chk("wp high", 8'h01, statusTwo);
        wsr(8'h1C, 8'h00);
        chk("lockdown", 8'h02, statusOne);
        rst_cycle;
        chk("after power", 8'h00, statusTwo);
        wsr(8'h80, 8'h01);
        wsr(8'h00, 8'h00);
        chk("permanent lock", 8'h82, statusOne);
        rst_cycle;
        $display("test status done");
        cmd(`FRG_CMD_WREN);
        cmd(`FRG_CMD_RSTEN);
        cmd(`FRG_CMD_WREN);
        cmd(`FRG_CMD_RST);
        chk("reset dropped", 8'h01, {6'h00, resetBusy, writeLatch});
        cmd(`FRG_CMD_RSTEN);
        cmd(`FRG_CMD_RST);
        chk("reset taken", 8'h02, {6'h00, resetBusy, writeLatch});
        cmd(`FRG_CMD_WREN);
        chb("cmd in reset", 1'b0, writeLatch);
        waitq;
        cmd(`FRG_CMD_PD);
        cmd(`FRG_CMD_WREN);
        chb("latch in pd", 1'b0, writeLatch);
        cmd(`FRG_CMD_RPD);
        cmd(`FRG_CMD_WREN);
        chb("latch after pd", 1'b1, writeLatch);
        $display("test soft reset done");
        cmd(`FRG_CMD_PP);
        sharedPinN <= 1'b0;
        idle(50);
        sharedPinN <= 1'b1;
        idle(5);
        chb("short pulse", 1'b1, busy);
        sharedPinN <= 1'b0;
        for (j = 0; j < 200 && opAbort !== 1'b1; j = j + 1)
            @(posedge core_clk);
        chb("abort", 1'b1, opAbort);
        idle(2);
        chk("aborted", 8'h00, {6'h00, busy, writeLatch});
        cmd(`FRG_CMD_WREN);
        chb("cmd with pin low", 1'b0, writeLatch);
        sharedPinN <= 1'b1;
        resetPinSel <= 1'b0;
        idle(5);
        fork
            rd(`FRG_CMD_RDSR1);
            begin
                idle(40);
                sharedPinN <= 1'b0;
                idle(12);
                chk("pause", 8'h01, {5'h00, spiDataOutEn, hwResetLow, pauseActive});
                sharedPinN <= 1'b1;
            end
        join
        $display("test pins done");
        complete_run;
    end
endmodule
